//--- rtl/psc_pkg.sv
// Purpose: constants for the setup and overvoltage command slice
// Assumes: command codes arrive already decoded from the bus framing
// Notes:   all voltage words are two-byte direct-coded values
package psc_pkg;
  localparam logic [7:0]  CMD_FEATURE_REPORT   = 8'h19;
  localparam logic [7:0]  CMD_VOLT_FORMAT      = 8'h20;
  localparam logic [7:0]  CMD_MARGIN_HIGH      = 8'h25;
  localparam logic [7:0]  CMD_MARGIN_LOW       = 8'h26;
  localparam logic [7:0]  CMD_MONITOR_SCALE    = 8'h2a;
  localparam logic [7:0]  CMD_CAL_GAIN         = 8'h38;
  localparam logic [7:0]  CMD_OV_FAULT_LIMIT   = 8'h40;
  localparam logic [7:0]  CMD_OV_WARN_LIMIT    = 8'h42;
  localparam logic [7:0]  CMD_CHECKSUM_REPORT  = 8'hfe;
  localparam logic [7:0]  VOLT_FORMAT_DIRECT   = 8'h40;
  localparam logic [1:0]  FEAT_SPEED_400K      = 2'h1;
  localparam int          FEAT_ALERT_BIT       = 4;
  localparam logic [15:0] SEL_MAIN             = 16'h0000;
  localparam logic [15:0] SEL_SECONDARY        = 16'h0001;
  localparam logic [15:0] SEL_RAM              = 16'h0002;
  localparam logic [15:0] CHECKSUM_NONE        = 16'hffff;
  localparam logic [15:0] SCALE_UNITY          = 16'h7fff;
  localparam logic [15:0] WORD_RESET           = 16'h0000;
  // hysteresis: clear below limit*(1-1/50) = 2 percent
  localparam int          HYST_SHIFT_DIV       = 50;
  localparam int          WORD_W               = 16;
  typedef enum logic [1:0] {PSC_MRG_IDLE, PSC_MRG_HIGH, PSC_MRG_LOW} psc_margin_e;
endpackage : psc_pkg

//--- rtl/psc_ov_detect.sv
// Purpose: one overvoltage comparator with 2 percent release hysteresis
// Assumes: voltage and limit share the same direct coding
// Notes:   flag sets above limit, clears only below 98 percent of limit
`timescale 1ns/10ps
module psc_ov_detect
  import psc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [WORD_W-1:0] volt,
  input  wire logic [WORD_W-1:0] limit,
  output logic                   active
);
  logic [WORD_W-1:0] release_lvl;
  logic              active_ff;
  logic              nxt_active;
  logic [WORD_W-1:0] hyst_amt;
  assign hyst_amt    = WORD_W'(({16'h0000, limit} + 32'(HYST_SHIFT_DIV - 1)) / HYST_SHIFT_DIV);
  assign release_lvl = limit - hyst_amt;
  assign nxt_active  = active_ff ? (volt > release_lvl) : (volt > limit);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active;
    end
  end
  assign active = active_ff;
  hold_until_low_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (active_ff && volt > release_lvl) |=> active_ff)
    else $error("ov condition dropped above release level");
endmodule : psc_ov_detect

//--- rtl/psc_cmd_core.sv
// Purpose: setup, report and overvoltage command handling
// Assumes: cmd_wr/cmd_rd are single-cycle strobes from the bus engine
// Notes:   voltages are actual supply volts, converter side scaled by factor
//
// How it works
// - checksum report returns one 16-bit crc of last selected memory
// - only ram, main and secondary copies selectable; no single-area crc
// - before any selection write, checksum read returns ffff
// - feature byte: bit7 zero, bits 3:0 zero, read-only
// - feature bits 6:5 read 01 for 400 khz
// - feature bit 4 mirrors alert enable in mode config
// - format report is read-only and returns 40h
// - writing format report sets comm/memory error summary bit
// - new margin setpoint applies only after a fresh margin command
// - margin failure: keep retrying, set summary and page fault bits, alert
// - setpoints, scale, gain and limits are two-byte direct words
// - scale factor is word over 32767; 7fff means unity
// - command volts are supply volts; converter side uses scale factor
// - calibration gain word in 0.1 milliohm units
// - ov fault: set ov and vout summary, fault flag, respond, alert
// - ov warning: set vout summary and warning flag, alert, no response
// - ov conditions hold until voltage drops 2 percent below limit
// - selection 0 main, 1 secondary, 2 ram
`timescale 1ns/10ps
module psc_cmd_core
  import psc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                cmd_wr,
  input  wire logic                cmd_rd,
  input  wire logic [7:0]          cmd_code,
  input  wire logic [WORD_W-1:0]   cmd_wdata,
  output logic      [WORD_W-1:0]   cmd_rdata,
  input  wire logic                alert_enable,
  input  wire logic                margin_high_cmd,
  input  wire logic                margin_low_cmd,
  input  wire logic                margin_off_cmd,
  input  wire logic                margin_fail,
  input  wire logic [WORD_W-1:0]   crc_main,
  input  wire logic [WORD_W-1:0]   crc_secondary,
  input  wire logic [WORD_W-1:0]   crc_ram,
  input  wire logic [WORD_W-1:0]   monitored_volt,
  input  wire logic                status_clear,
  output logic      [WORD_W-1:0]   margin_target,
  output logic                     margin_retry,
  output logic      [WORD_W-1:0]   monitor_scale,
  output logic      [WORD_W-1:0]   cal_gain,
  output logic                     comm_memory_error_flag,
  output logic                     margin_summary,
  output logic                     margin_fault_page,
  output logic                     vout_summary,
  output logic                     ov_summary,
  output logic                     overvoltage_fault_flag,
  output logic                     overvoltage_warning_flag,
  output logic                     fault_action_req,
  output logic                     alert_out
);
  //////////////////////////////////////////////////////////////////////////////
  logic [WORD_W-1:0] mhigh_ff, mlow_ff, scale_ff, gain_ff, ovf_ff, ovw_ff;
  logic [WORD_W-1:0] crc_sel_ff, target_ff, rdata_ff, nxt_target, nxt_rdata;
  logic              crc_valid_ff, cml_ff, msum_ff, mpage_ff;
  logic              vsum_ff, ovsum_ff, ovflag_ff, owflag_ff, fresp_ff;
  logic              nxt_cml, nxt_msum, nxt_mpage, nxt_vsum, nxt_ovsum;
  logic              nxt_ovflag, nxt_owflag, nxt_fresp;
  logic              ovf_active, ovw_active, ovf_active_q;
  psc_margin_e       mode_ff, nxt_mode;
  logic [7:0]        feature_byte;
  logic [WORD_W-1:0] crc_pick;
  logic              wr_mh, wr_ml, wr_sc, wr_gn, wr_ovf, wr_ovw, wr_crc, wr_fmt;

  function automatic logic hit(input logic [7:0] code, input logic [7:0] want);
    return code == want;
  endfunction : hit

  assign wr_mh  = cmd_wr && hit(cmd_code, CMD_MARGIN_HIGH);
  assign wr_ml  = cmd_wr && hit(cmd_code, CMD_MARGIN_LOW);
  assign wr_sc  = cmd_wr && hit(cmd_code, CMD_MONITOR_SCALE);
  assign wr_gn  = cmd_wr && hit(cmd_code, CMD_CAL_GAIN);
  assign wr_ovf = cmd_wr && hit(cmd_code, CMD_OV_FAULT_LIMIT);
  assign wr_ovw = cmd_wr && hit(cmd_code, CMD_OV_WARN_LIMIT);
  assign wr_crc = cmd_wr && hit(cmd_code, CMD_CHECKSUM_REPORT);
  assign wr_fmt = cmd_wr && hit(cmd_code, CMD_VOLT_FORMAT);

  //////////////////////////////////////////////////////////////////////////////
  // feature byte and checksum select
  assign feature_byte = {1'b0, FEAT_SPEED_400K, alert_enable, 4'h0};
  assign crc_pick = (crc_sel_ff == SEL_MAIN)      ? crc_main :
                    (crc_sel_ff == SEL_SECONDARY) ? crc_secondary :
                    (crc_sel_ff == SEL_RAM)       ? crc_ram :
                                                    CHECKSUM_NONE;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (cmd_rd) begin
      if (hit(cmd_code, CMD_FEATURE_REPORT)) begin
        nxt_rdata = {8'h00, feature_byte};
      end else if (hit(cmd_code, CMD_VOLT_FORMAT)) begin
        nxt_rdata = {8'h00, VOLT_FORMAT_DIRECT};
      end else if (hit(cmd_code, CMD_MARGIN_HIGH)) begin
        nxt_rdata = mhigh_ff;
      end else if (hit(cmd_code, CMD_MARGIN_LOW)) begin
        nxt_rdata = mlow_ff;
      end else if (hit(cmd_code, CMD_MONITOR_SCALE)) begin
        nxt_rdata = scale_ff;
      end else if (hit(cmd_code, CMD_CAL_GAIN)) begin
        nxt_rdata = gain_ff;
      end else if (hit(cmd_code, CMD_OV_FAULT_LIMIT)) begin
        nxt_rdata = ovf_ff;
      end else if (hit(cmd_code, CMD_OV_WARN_LIMIT)) begin
        nxt_rdata = ovw_ff;
      end else if (hit(cmd_code, CMD_CHECKSUM_REPORT)) begin
        nxt_rdata = crc_valid_ff ? crc_pick : CHECKSUM_NONE;
      end else begin
        nxt_rdata = WORD_RESET;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // margin target: latched only on a fresh margin command
  always_comb begin
    nxt_mode   = mode_ff;
    nxt_target = target_ff;
    if (margin_high_cmd) begin
      nxt_mode   = PSC_MRG_HIGH;
      nxt_target = mhigh_ff;
    end else if (margin_low_cmd) begin
      nxt_mode   = PSC_MRG_LOW;
      nxt_target = mlow_ff;
    end else if (margin_off_cmd) begin
      nxt_mode   = PSC_MRG_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // overvoltage detection
  psc_ov_detect u_ovf (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .volt    (monitored_volt),
    .limit   (ovf_ff),
    .active  (ovf_active)
  );
  psc_ov_detect u_ovw (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .volt    (monitored_volt),
    .limit   (ovw_ff),
    .active  (ovw_active)
  );

  // sticky flags: a set in the same cycle as a clear wins
  assign nxt_cml    = wr_fmt || (cml_ff && !status_clear);
  assign nxt_msum   = (margin_fail && mode_ff != PSC_MRG_IDLE)
                      || (msum_ff && !status_clear);
  assign nxt_mpage  = (margin_fail && mode_ff != PSC_MRG_IDLE)
                      || (mpage_ff && !status_clear);
  assign nxt_ovflag = ovf_active || (ovflag_ff && !status_clear);
  assign nxt_ovsum  = ovf_active || (ovsum_ff && !status_clear);
  assign nxt_owflag = ovw_active || (owflag_ff && !status_clear);
  assign nxt_vsum   = ovf_active || ovw_active || (vsum_ff && !status_clear);
  assign nxt_fresp  = ovf_active && !ovf_active_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mhigh_ff <= WORD_RESET;
      mlow_ff  <= WORD_RESET;
      scale_ff <= SCALE_UNITY;
      gain_ff  <= WORD_RESET;
      ovf_ff   <= WORD_RESET;
      ovw_ff   <= WORD_RESET;
    end else begin
      // 16-bit direct words stored whole; feature byte has no store
      if (wr_mh)  mhigh_ff <= cmd_wdata;
      if (wr_ml)  mlow_ff  <= cmd_wdata;
      if (wr_sc)  scale_ff <= cmd_wdata;
      if (wr_gn)  gain_ff  <= cmd_wdata;
      if (wr_ovf) ovf_ff   <= cmd_wdata;
      if (wr_ovw) ovw_ff   <= cmd_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      crc_sel_ff   <= CHECKSUM_NONE;
      crc_valid_ff <= 1'b0;
      rdata_ff     <= WORD_RESET;
      mode_ff      <= PSC_MRG_IDLE;
      target_ff    <= WORD_RESET;
    end else begin
      if (wr_crc) crc_sel_ff   <= cmd_wdata;
      if (wr_crc) crc_valid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      mode_ff   <= nxt_mode;
      target_ff <= nxt_target;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cml_ff       <= 1'b0;
      msum_ff      <= 1'b0;
      mpage_ff     <= 1'b0;
      ovflag_ff    <= 1'b0;
      ovsum_ff     <= 1'b0;
      owflag_ff    <= 1'b0;
      vsum_ff      <= 1'b0;
      fresp_ff     <= 1'b0;
      ovf_active_q <= 1'b0;
    end else begin
      cml_ff       <= nxt_cml;
      msum_ff      <= nxt_msum;
      mpage_ff     <= nxt_mpage;
      ovflag_ff    <= nxt_ovflag;
      ovsum_ff     <= nxt_ovsum;
      owflag_ff    <= nxt_owflag;
      vsum_ff      <= nxt_vsum;
      fresp_ff     <= nxt_fresp;
      ovf_active_q <= ovf_active;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign cmd_rdata                = rdata_ff;
  assign margin_target            = target_ff;
  assign margin_retry             = msum_ff && mode_ff != PSC_MRG_IDLE;
  assign monitor_scale            = scale_ff;
  assign cal_gain                 = gain_ff;
  assign comm_memory_error_flag   = cml_ff;
  assign margin_summary           = msum_ff;
  assign margin_fault_page        = mpage_ff;
  assign vout_summary             = vsum_ff;
  assign ov_summary               = ovsum_ff;
  assign overvoltage_fault_flag   = ovflag_ff;
  assign overvoltage_warning_flag = owflag_ff;
  assign fault_action_req         = fresp_ff;
  assign alert_out = alert_enable && (cml_ff || msum_ff || vsum_ff);

  //////////////////////////////////////////////////////////////////////////////
  // selection write, one idle cycle, then a checksum read
  sequence crc_sel_seq;
    (wr_crc && cmd_wdata == SEL_SECONDARY) ##1 !cmd_wr
      ##1 (cmd_rd && !cmd_wr && hit(cmd_code, CMD_CHECKSUM_REPORT));
  endsequence
  sequence crc_main_seq;
    (wr_crc && cmd_wdata == SEL_MAIN) ##1 !cmd_wr
      ##1 (cmd_rd && !cmd_wr && hit(cmd_code, CMD_CHECKSUM_REPORT));
  endsequence
  sequence crc_ram_seq;
    (wr_crc && cmd_wdata == SEL_RAM) ##1 !cmd_wr
      ##1 (cmd_rd && !cmd_wr && hit(cmd_code, CMD_CHECKSUM_REPORT));
  endsequence
  crc_main_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    crc_main_seq |=> rdata_ff == $past(crc_main))
    else $error("main checksum read did not follow selection");
  crc_ram_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    crc_ram_seq |=> rdata_ff == $past(crc_ram))
    else $error("ram checksum read did not follow selection");
  crc_other_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (crc_valid_ff && crc_sel_ff > SEL_RAM && cmd_rd && hit(cmd_code, CMD_CHECKSUM_REPORT))
      |=> rdata_ff == CHECKSUM_NONE)
    else $error("unsupported checksum selection not ffff");
  alert_mask_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    !alert_enable |-> !alert_out)
    else $error("alert raised while disabled");
  fault_pulse_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    fault_action_req |=> !fault_action_req)
    else $error("fault response request longer than one cycle");
  word_store_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_ovf |=> ovf_ff == $past(cmd_wdata))
    else $error("limit word not stored whole");
  crc_select_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    crc_sel_seq |=> rdata_ff == $past(crc_secondary))
    else $error("checksum read did not follow selection");
  crc_unset_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!crc_valid_ff && cmd_rd && hit(cmd_code, CMD_CHECKSUM_REPORT)) |=> rdata_ff == CHECKSUM_NONE)
    else $error("unselected checksum read not ffff");
  feature_byte_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_rd && hit(cmd_code, CMD_FEATURE_REPORT))
      |=> rdata_ff == {9'h000, FEAT_SPEED_400K, $past(alert_enable), 4'h0})
    else $error("feature byte wrong");
  format_read_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_rd && hit(cmd_code, CMD_VOLT_FORMAT)) |=> rdata_ff == {8'h00, VOLT_FORMAT_DIRECT})
    else $error("format report not 40h");
  format_write_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_fmt |=> comm_memory_error_flag)
    else $error("format write did not flag error");
  margin_hold_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!margin_high_cmd && !margin_low_cmd) |=> $stable(margin_target))
    else $error("margin target moved without command");
  margin_fault_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (margin_fail && mode_ff != PSC_MRG_IDLE) |=> (margin_summary && margin_fault_page))
    else $error("margin failure not flagged");
  ov_fault_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(ovf_active) |=> (ov_summary && vout_summary && overvoltage_fault_flag
                           && fault_action_req))
    else $error("ov fault side effects missing");
  ov_warn_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ovw_active && !ovf_active && !ovf_active_q) |=> (overvoltage_warning_flag
                                                      && vout_summary && !fault_action_req))
    else $error("ov warning side effects wrong");
  feature_write_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_wr && hit(cmd_code, CMD_FEATURE_REPORT)) |=> ($stable(mhigh_ff) && $stable(ovf_ff)
                                                       && $stable(scale_ff)))
    else $error("feature write changed settings");
endmodule : psc_cmd_core

//--- tb/psc_host_model.sv
// Purpose: host model issuing setup, report and limit commands
// Assumes: one strobe per transfer, changed just after a rising edge
// Notes:   never issues nonvolatile store commands
`timescale 1ns/10ps
module psc_host_model (
  input  wire logic                      ref_clk,
  input  wire logic [psc_pkg::WORD_W-1:0] cmd_rdata,
  output logic                            cmd_wr,
  output logic                            cmd_rd,
  output logic      [7:0]                 cmd_code,
  output logic      [psc_pkg::WORD_W-1:0] cmd_wdata
);
  import psc_pkg::*;
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // only setup, report and limit codes are ever sent, so no store misuse
  task automatic write_word(input logic [7:0] code, input logic [WORD_W-1:0] data);
    @(posedge ref_clk);
    cmd_wr    <= 1'b1;
    cmd_code  <= code;
    cmd_wdata <= data; // whole two-byte word
    @(posedge ref_clk);
    cmd_wr    <= 1'b0;
    cmd_wdata <= ~data; // released data does not keep its last value
  endtask : write_word
  task automatic read_word(input logic [7:0] code, output logic [WORD_W-1:0] data);
    @(posedge ref_clk);
    cmd_rd   <= 1'b1;
    cmd_code <= code;
    @(posedge ref_clk);
    cmd_rd   <= 1'b0;
    // registered answer stands from the edge after the strobe
    @(posedge ref_clk);
    data = cmd_rdata;
  endtask : read_word
endmodule : psc_host_model

//--- tb/tb_top.sv
// Purpose: self-checking bench for the command core
// Assumes: 10 MHz clock, reset held 16 cycles
// Notes:   expectations are worked out here from constants
`timescale 1ns/10ps
module tb_top;
  import psc_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0;
  logic cmd_wr, cmd_rd, alert_enable = 1'b1, status_clear = 1'b0, margin_fail = 1'b0;
  logic margin_high_cmd = 1'b0, margin_low_cmd = 1'b0, margin_off_cmd = 1'b0;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, margin_target, monitor_scale, cal_gain, rd;
  logic [15:0] crc_main = 16'h1a2b, crc_secondary = 16'h3c4d, crc_ram = 16'h5e6f;
  logic [15:0] monitored_volt = 16'h0000;
  logic margin_retry, comm_memory_error_flag, margin_summary, margin_fault_page;
  logic vout_summary, ov_summary, overvoltage_fault_flag, overvoltage_warning_flag;
  logic fault_action_req, alert_out;
  int n_fail = 0, samples_checked = 0;
  always #50 ref_clk = ~ref_clk;
  psc_host_model host (.ref_clk(ref_clk), .cmd_rdata(cmd_rdata), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  psc_cmd_core dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .alert_enable(alert_enable), .margin_high_cmd(margin_high_cmd),
    .margin_low_cmd(margin_low_cmd), .margin_off_cmd(margin_off_cmd),
    .margin_fail(margin_fail), .crc_main(crc_main), .crc_secondary(crc_secondary),
    .crc_ram(crc_ram), .monitored_volt(monitored_volt), .status_clear(status_clear),
    .margin_target(margin_target), .margin_retry(margin_retry),
    .monitor_scale(monitor_scale), .cal_gain(cal_gain),
    .comm_memory_error_flag(comm_memory_error_flag), .margin_summary(margin_summary),
    .margin_fault_page(margin_fault_page), .vout_summary(vout_summary),
    .ov_summary(ov_summary), .overvoltage_fault_flag(overvoltage_fault_flag),
    .overvoltage_warning_flag(overvoltage_warning_flag),
    .fault_action_req(fault_action_req), .alert_out(alert_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_clk
  task automatic t_checksum;
    host.read_word(CMD_CHECKSUM_REPORT, rd);
    chk(rd, 16'hffff);
    host.write_word(CMD_CHECKSUM_REPORT, SEL_SECONDARY);
    host.read_word(CMD_CHECKSUM_REPORT, rd);
    chk(rd, crc_secondary);
    host.write_word(CMD_CHECKSUM_REPORT, SEL_MAIN);
    host.read_word(CMD_CHECKSUM_REPORT, rd);
    chk(rd, crc_main);
    host.write_word(CMD_CHECKSUM_REPORT, SEL_RAM);
    host.read_word(CMD_CHECKSUM_REPORT, rd);
    chk(rd, crc_ram);
    host.write_word(CMD_CHECKSUM_REPORT, 16'h0003);
    host.read_word(CMD_CHECKSUM_REPORT, rd);
    chk(rd, 16'hffff);
  endtask : t_checksum
  task automatic t_reports;
    host.read_word(CMD_FEATURE_REPORT, rd);
    chk(rd, 16'h0030);
    host.write_word(CMD_FEATURE_REPORT, 16'h00ff);
    alert_enable <= 1'b0;
    host.read_word(CMD_FEATURE_REPORT, rd);
    chk(rd, 16'h0020);
    alert_enable <= 1'b1;
    chk(monitor_scale, SCALE_UNITY);
    chk({15'h0, comm_memory_error_flag}, 16'h0000);
    host.read_word(CMD_VOLT_FORMAT, rd);
    chk(rd, 16'h0040);
    host.write_word(CMD_VOLT_FORMAT, 16'h0000);
    host.read_word(CMD_VOLT_FORMAT, rd);
    chk(rd, 16'h0040);
    chk({15'h0, comm_memory_error_flag}, 16'h0001);
  endtask : t_reports
  task automatic t_settings;
    host.read_word(CMD_MONITOR_SCALE, rd);
    chk(rd, 16'h7fff);
    host.write_word(CMD_MONITOR_SCALE, 16'h1333);
    host.write_word(CMD_CAL_GAIN, 16'h1388);
    host.read_word(CMD_MONITOR_SCALE, rd);
    chk(rd, 16'h1333);
    chk(monitor_scale, 16'h1333);
    host.read_word(CMD_CAL_GAIN, rd);
    chk(rd, 16'h1388);
    chk(cal_gain, 16'h1388);
  endtask : t_settings
  task automatic t_margin;
    host.write_word(CMD_MARGIN_HIGH, 16'h1111);
    host.write_word(CMD_MARGIN_LOW, 16'h0777);
    margin_high_cmd <= 1'b1;
    wait_clk(1);
    margin_high_cmd <= 1'b0;
    wait_clk(2);
    chk(margin_target, 16'h1111);
    host.write_word(CMD_MARGIN_HIGH, 16'h2222);
    wait_clk(2);
    chk(margin_target, 16'h1111);
    margin_high_cmd <= 1'b1;
    wait_clk(1);
    margin_high_cmd <= 1'b0;
    wait_clk(2);
    chk(margin_target, 16'h2222);
    margin_low_cmd <= 1'b1;
    wait_clk(1);
    margin_low_cmd <= 1'b0;
    margin_fail <= 1'b1;
    wait_clk(4);
    chk(margin_target, 16'h0777);
    chk({margin_retry, margin_summary, margin_fault_page, alert_out}, 16'h000f);
    margin_fail <= 1'b0;
    margin_off_cmd <= 1'b1;
    status_clear <= 1'b1;
    wait_clk(1);
    margin_off_cmd <= 1'b0;
    status_clear <= 1'b0;
    wait_clk(2);
    chk({margin_retry, margin_summary, margin_fault_page, alert_out}, 16'h0000);
  endtask : t_margin
  task automatic t_overvolt;
    int hits = 0, at = 0;
    host.write_word(CMD_OV_FAULT_LIMIT, 16'h1000);
    host.write_word(CMD_OV_WARN_LIMIT, 16'h0800);
    monitored_volt <= 16'h0900;
    wait_clk(4);
    chk({vout_summary, overvoltage_warning_flag, ov_summary, fault_action_req}, 16'hc);
    chk({overvoltage_fault_flag, alert_out}, 16'h1);
    monitored_volt <= 16'h1001;
    // pulse is looked at mid-cycle, clear of its launching edge
    for (int i = 1; i <= 6; i++) begin
      @(negedge ref_clk);
      if (fault_action_req === 1'b1) begin
        hits++;
        at = i;
      end
    end
    @(posedge ref_clk);
    chk(16'(hits * 16 + at), 16'h0013);
    chk({ov_summary, vout_summary, overvoltage_fault_flag}, 16'h7);
    monitored_volt <= 16'h0faf;
    wait_clk(3);
    status_clear <= 1'b1;
    wait_clk(1);
    status_clear <= 1'b0;
    wait_clk(3);
    chk({15'h0, overvoltage_fault_flag}, 16'h1);
    monitored_volt <= 16'h0fae;
    wait_clk(3);
    status_clear <= 1'b1;
    wait_clk(1);
    status_clear <= 1'b0;
    wait_clk(3);
    chk({overvoltage_fault_flag, overvoltage_warning_flag}, 16'h1);
  endtask : t_overvolt
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_checksum();
    t_reports();
    t_settings();
    t_margin();
    t_overvolt();
    summarize();
  end
  initial begin
    #(100 * 3000);
    n_fail++;
    summarize();
  end
endmodule : tb_top
